// *** core/wess_pkg.sv ***
// package for the wake enable / smi status slice: offsets, bit positions, reset values
// assumes an 8-bit register port and one 100 MHz clock domain
`default_nettype none
package wess_pkg;
   // port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NSRC   = 8;            // sources per enable register
   localparam int SYNC_W = 9;            // eight general inputs plus printer acknowledge
   localparam int IRQ_W  = 3;

   // register offsets
   localparam logic [ADDR_W-1:0] OFF_GPIO_WAKE_EN5   = 8'h0E;
   localparam logic [ADDR_W-1:0] OFF_PERIPH_WAKE_EN6 = 8'h0F;
   localparam logic [ADDR_W-1:0] OFF_SMI_STATUS_ONE  = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_GPIO_WAKE_STS   = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_WAKE_CTRL       = 8'h21;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS      = 8'h22;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK        = 8'h23;

   // reset values
   localparam logic [DATA_W-1:0] RST_EN5      = 8'h00;
   localparam logic [DATA_W-1:0] RST_EN6      = 8'h00;
   localparam logic [DATA_W-1:0] RST_SMI_ONE  = 8'h02;
   localparam logic [DATA_W-1:0] RST_ZERO     = 8'h00;
   localparam logic [IRQ_W-1:0]  RST_IRQ      = 3'h0;
   // synchroniser reset at the pins' idle levels: acknowledge high, general inputs low
   localparam logic [SYNC_W-1:0] RST_SYNC     = 9'h100;

   // peripheral enable register bit positions
   localparam int EN6_PARALLEL = 0;
   localparam int EN6_SERIAL2  = 1;
   localparam int EN6_SERIAL1  = 2;
   localparam int EN6_FLOPPY   = 3;
   localparam int EN6_MOUSE    = 4;
   localparam int EN6_KEYBOARD = 5;
   localparam int EN6_WATCHDOG = 6;
   localparam int EN6_SMBUS    = 7;

   // smi status one bit positions; 0, 5 and 6 read zero
   localparam int SMI_PARALLEL = 1;
   localparam int SMI_SERIAL2  = 2;
   localparam int SMI_SERIAL1  = 3;
   localparam int SMI_FLOPPY   = 4;
   localparam int SMI_WATCHDOG = 7;

   // control and interrupt bit positions
   localparam int CTRL_GLOBAL_WAKE = 0;
   localparam int IRQ_GPIO_WAKE    = 0;
   localparam int IRQ_SMI_CHANGE   = 1;
   localparam int IRQ_WAKE_BUS     = 2;
endpackage : wess_pkg
`default_nettype wire

// *** core/wess_irq_if.sv ***
// interface between the slice top and its interrupt status / mask block
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface wess_irq_if;
   import wess_pkg::*;
   logic [IRQ_W-1:0] evt;        // one-cycle event pulses
   logic             wr_sts;     // write-one-to-clear strobe
   logic             wr_mask;    // mask write strobe
   logic [IRQ_W-1:0] wdata;
   logic [IRQ_W-1:0] sts;
   logic [IRQ_W-1:0] mask;
   logic             irq;
   modport top  (output evt, wr_sts, wr_mask, wdata, input sts, mask, irq);
   modport ctrl (input evt, wr_sts, wr_mask, wdata, output sts, mask, irq);
endinterface : wess_irq_if
`default_nettype wire

// *** core/wess_sync.sv ***
// two-flop synchroniser, one per bit, for pin inputs
// assumes inputs are asynchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module wess_sync (
   input  wire logic                        clk_in,
   input  wire logic                        rst_in,
   input  wire logic [wess_pkg::SYNC_W-1:0] d_in,
   output logic      [wess_pkg::SYNC_W-1:0] q_out
);
   import wess_pkg::*;

   typedef struct packed {
      logic [SYNC_W-1:0] meta;
      logic [SYNC_W-1:0] stable;
   } wess_sync_t;

   wess_sync_t st_reg;
   wess_sync_t st_next;

   // per-bit chain; the first flop feeds only the second
   genvar i;
   generate
      for (i = 0; i < SYNC_W; i++) begin : g_bit
         always_comb begin
            st_next.meta[i]   = d_in[i];
            st_next.stable[i] = st_reg.meta[i];
         end
      end
   endgenerate

   always_ff @(posedge clk_in or posedge rst_in) begin
      // idle levels after reset, so no false acknowledge edge follows a reset
      if (rst_in) begin
         st_reg <= '{meta: RST_SYNC, stable: RST_SYNC};
      end else begin
         st_reg <= st_next;
      end
   end

   assign q_out = st_reg.stable;
endmodule : wess_sync
`default_nettype wire

// *** core/wess_irq.sv ***
// sticky interrupt status with write-one-to-clear, mask and one level output
// assumes event pulses and strobes come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module wess_irq (
   input  wire logic clk_in,
   input  wire logic rst_in,
   wess_irq_if.ctrl  bus
);
   import wess_pkg::*;

   typedef struct packed {
      logic [IRQ_W-1:0] sts;
      logic [IRQ_W-1:0] mask;
      logic             irq;
   } wess_irq_t;

   wess_irq_t st_reg;
   wess_irq_t st_next;

   // a new event beats a clear in the same cycle so it is never lost
   always_comb begin
      st_next      = st_reg;
      st_next.sts  = (bus.wr_sts ? (st_reg.sts & ~bus.wdata) : st_reg.sts) | bus.evt;
      if (bus.wr_mask) begin
         st_next.mask = bus.wdata;
      end
      st_next.irq  = |(st_next.sts & st_next.mask);
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_reg <= '{sts: RST_IRQ, mask: RST_IRQ, irq: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign bus.sts  = st_reg.sts;
   assign bus.mask = st_reg.mask;
   assign bus.irq  = st_reg.irq;
endmodule : wess_irq
`default_nettype wire

// *** core/wess_top.sv ***
// wake enable registers, peripheral wake status bus and first smi status register
// assumes rst_in is the standby-power reset; the other resets and peripheral
// sources are single-clock logic; general inputs and printer acknowledge are pins
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - enabled, latched, globally enabled source drives wake
// - disabled source still latched, never drives wake
// - enable five bits 0..7 are inputs 50..57
// - enable five cleared only by standby reset
// - enabled asserted peripheral drives wake status bus
// - disabled peripheral never drives wake status bus
// - enable six bit map: parallel..smbus
// - smi status follows sources, writes never clear
// - smi status bit map, reserved bits zero
// - smi status 0x02; parallel bit set on resets
// - inactive parallel port holds its bit at one
// - active parallel port bit follows acknowledge
module wess_top (
   input  wire logic                        clk_in,
   input  wire logic                        rst_in,
   input  wire logic                        main_power_reset_in,
   input  wire logic                        soft_reset_in,
   input  wire logic                        host_bus_reset_in,
   input  wire logic [wess_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [wess_pkg::DATA_W-1:0] wr_data_in,
   input  wire logic                        wr_en_in,
   input  wire logic                        rd_en_in,
   input  wire logic [wess_pkg::NSRC-1:0]   general_input_in,
   input  wire logic                        printer_acknowledge_n_in,
   input  wire logic                        parallel_port_active_in,
   input  wire logic                        parallel_port_irq_in,
   input  wire logic                        serial_two_irq_in,
   input  wire logic                        serial_one_irq_in,
   input  wire logic                        floppy_irq_in,
   input  wire logic                        mouse_irq_in,
   input  wire logic                        keyboard_irq_in,
   input  wire logic                        watchdog_event_in,
   input  wire logic                        smbus_ctrl_event_in,
   output logic      [wess_pkg::DATA_W-1:0] rd_data_out,
   output logic                             wake_output_n_out,
   output logic      [wess_pkg::NSRC-1:0]   wake_status_bus_out,
   output logic                             irq_out
);
   import wess_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] gpio_wake_enable_five;
      logic [DATA_W-1:0] peripheral_wake_enable_six;
      logic [DATA_W-1:0] smi_status_one;
      logic [DATA_W-1:0] gpio_wake_sts;
      logic              global_wake_output_enable;
      logic              wake_n;
      logic [NSRC-1:0]   wake_status_bus;
      logic [DATA_W-1:0] rd_data;
   } wess_state_t;

   wess_state_t st_reg;
   wess_state_t st_next;

   logic [SYNC_W-1:0] pins_sync;
   logic [NSRC-1:0]   gpio_sync;
   logic              ack_sync;
   logic [NSRC-1:0]   periph_src;
   logic              any_aux_reset;
   logic              wr_en5;
   logic              wr_en6;
   logic              wr_gsts;
   logic              wr_ctrl;

   wess_irq_if irq_bus ();

   // pins cross into the clock domain before anything reads them
   wess_sync u_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   ({printer_acknowledge_n_in, general_input_in}),
      .q_out  (pins_sync)
   );

   wess_irq u_irq (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .bus    (irq_bus.ctrl)
   );

   // bit n of the general input vector is input fifty plus n
   assign gpio_sync = pins_sync[NSRC-1:0];
   assign ack_sync  = pins_sync[NSRC];

   // peripheral sources gathered in enable-six order
   always_comb begin
      periph_src               = '0;
      periph_src[EN6_PARALLEL] = parallel_port_irq_in;
      periph_src[EN6_SERIAL2]  = serial_two_irq_in;
      periph_src[EN6_SERIAL1]  = serial_one_irq_in;
      periph_src[EN6_FLOPPY]   = floppy_irq_in;
      periph_src[EN6_MOUSE]    = mouse_irq_in;
      periph_src[EN6_KEYBOARD] = keyboard_irq_in;
      periph_src[EN6_WATCHDOG] = watchdog_event_in;
      periph_src[EN6_SMBUS]    = smbus_ctrl_event_in;
   end

   // write decode; the smi status offset takes no write at all
   assign any_aux_reset = main_power_reset_in | soft_reset_in | host_bus_reset_in;
   assign wr_en5  = wr_en_in && (addr_in == OFF_GPIO_WAKE_EN5);
   assign wr_en6  = wr_en_in && (addr_in == OFF_PERIPH_WAKE_EN6);
   assign wr_gsts = wr_en_in && (addr_in == OFF_GPIO_WAKE_STS);
   assign wr_ctrl = wr_en_in && (addr_in == OFF_WAKE_CTRL);

   // next-state of the whole slice
   always_comb begin
      st_next = st_reg;

      // enable registers ignore main-power, soft and host bus resets
      if (wr_en5) begin
         st_next.gpio_wake_enable_five = wr_data_in;
      end
      if (wr_en6) begin
         st_next.peripheral_wake_enable_six = wr_data_in;
      end
      if (wr_ctrl) begin
         st_next.global_wake_output_enable = wr_data_in[CTRL_GLOBAL_WAKE];
      end

      // latched wake status records every source whatever its enable; set beats clear
      st_next.gpio_wake_sts = (wr_gsts ? (st_reg.gpio_wake_sts & ~wr_data_in) : st_reg.gpio_wake_sts)
                              | gpio_sync;

      // level output, low while any enabled latched source and global enable hold
      st_next.wake_n = ~((|(st_reg.gpio_wake_sts & st_reg.gpio_wake_enable_five))
                         & st_reg.global_wake_output_enable);

      // only enabled peripherals reach the wake status bus
      st_next.wake_status_bus = periph_src & st_reg.peripheral_wake_enable_six;

      // smi status mirrors its sources; reserved bits stay zero
      st_next.smi_status_one               = '0;
      st_next.smi_status_one[SMI_SERIAL2]  = serial_two_irq_in;
      st_next.smi_status_one[SMI_SERIAL1]  = serial_one_irq_in;
      st_next.smi_status_one[SMI_FLOPPY]   = floppy_irq_in;
      st_next.smi_status_one[SMI_WATCHDOG] = watchdog_event_in;
      if (any_aux_reset || !parallel_port_active_in) begin
         st_next.smi_status_one[SMI_PARALLEL] = 1'b1;
      end else begin
         st_next.smi_status_one[SMI_PARALLEL] = ack_sync;
      end

      // read data stands only in the cycle after the strobe
      st_next.rd_data = RST_ZERO;
      if (rd_en_in) begin
         case (addr_in)
            OFF_GPIO_WAKE_EN5:   st_next.rd_data = st_reg.gpio_wake_enable_five;
            OFF_PERIPH_WAKE_EN6: st_next.rd_data = st_reg.peripheral_wake_enable_six;
            OFF_SMI_STATUS_ONE:  st_next.rd_data = st_reg.smi_status_one;
            OFF_GPIO_WAKE_STS:   st_next.rd_data = st_reg.gpio_wake_sts;
            OFF_WAKE_CTRL:       st_next.rd_data = {7'h00, st_reg.global_wake_output_enable};
            OFF_IRQ_STATUS:      st_next.rd_data = {5'h00, irq_bus.sts};
            OFF_IRQ_MASK:        st_next.rd_data = {5'h00, irq_bus.mask};
            default:             st_next.rd_data = RST_ZERO;
         endcase
      end
   end

   // interrupt events: new wake latch, smi change, new wake bus bit
   always_comb begin
      irq_bus.evt                 = '0;
      irq_bus.evt[IRQ_GPIO_WAKE]  = |(st_next.gpio_wake_sts & ~st_reg.gpio_wake_sts);
      irq_bus.evt[IRQ_SMI_CHANGE] = |(st_next.smi_status_one ^ st_reg.smi_status_one);
      irq_bus.evt[IRQ_WAKE_BUS]   = |(st_next.wake_status_bus & ~st_reg.wake_status_bus);
      irq_bus.wr_sts              = wr_en_in && (addr_in == OFF_IRQ_STATUS);
      irq_bus.wr_mask             = wr_en_in && (addr_in == OFF_IRQ_MASK);
      irq_bus.wdata               = wr_data_in[IRQ_W-1:0];
   end

   // standby-power reset is the only reset that touches the enables
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_reg <= '{gpio_wake_enable_five:      RST_EN5,
                     peripheral_wake_enable_six: RST_EN6,
                     smi_status_one:             RST_SMI_ONE,
                     gpio_wake_sts:              RST_ZERO,
                     global_wake_output_enable:  1'b0,
                     wake_n:                     1'b1,
                     wake_status_bus:            RST_ZERO,
                     rd_data:                    RST_ZERO};
      end else begin
         st_reg <= st_next;
      end
   end

   assign rd_data_out         = st_reg.rd_data;
   assign wake_output_n_out   = st_reg.wake_n;
   assign wake_status_bus_out = st_reg.wake_status_bus;
   assign irq_out             = irq_bus.irq;

   // ---- checks ----
   sequence s_wake_cond;
      (|(st_reg.gpio_wake_sts & st_reg.gpio_wake_enable_five)) && st_reg.global_wake_output_enable;
   endsequence

   sequence s_rd_en5;
      rd_en_in && (addr_in == OFF_GPIO_WAKE_EN5);
   endsequence

   sequence s_rd_smi;
      rd_en_in && (addr_in == OFF_SMI_STATUS_ONE);
   endsequence

   AST_WAKE_ON: assert property (
      @(posedge clk_in) disable iff (rst_in)
      s_wake_cond |=> !wake_output_n_out)
      else $error("wake output not asserted for enabled latched source");

   AST_WAKE_OFF: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !(|(st_reg.gpio_wake_sts & st_reg.gpio_wake_enable_five)) |=> wake_output_n_out)
      else $error("wake output asserted without enabled source");

   AST_STS_LATCH: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (gpio_sync != 8'h00) |=> ((st_reg.gpio_wake_sts & $past(gpio_sync)) == $past(gpio_sync)))
      else $error("wake status failed to latch a source");

   AST_EN5_READ: assert property (
      @(posedge clk_in) disable iff (rst_in)
      s_rd_en5 |=> (rd_data_out == $past(st_reg.gpio_wake_enable_five)))
      else $error("enable five read back wrong");

   AST_EN5_KEEP: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (any_aux_reset && !wr_en5) |=> $stable(st_reg.gpio_wake_enable_five))
      else $error("enable five changed by a non-standby reset");

   AST_BUS_SET: assert property (
      @(posedge clk_in) disable iff (rst_in)
      ((periph_src & st_reg.peripheral_wake_enable_six) != 8'h00)
      |=> (wake_status_bus_out == $past(periph_src & st_reg.peripheral_wake_enable_six)))
      else $error("wake status bus missed an enabled source");

   AST_BUS_MASK: assert property (
      @(posedge clk_in) disable iff (rst_in)
      1'b1 |=> ((wake_status_bus_out & ~$past(st_reg.peripheral_wake_enable_six)) == 8'h00))
      else $error("wake status bus driven by a disabled source");

   AST_SMI_NOCLR: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (wr_en_in && (addr_in == OFF_SMI_STATUS_ONE) && watchdog_event_in)
      |=> st_reg.smi_status_one[SMI_WATCHDOG])
      else $error("smi status cleared by a write");

   AST_SMI_READ: assert property (
      @(posedge clk_in) disable iff (rst_in)
      s_rd_smi |=> ((rd_data_out & 8'h61) == 8'h00) && (rd_data_out == $past(st_reg.smi_status_one)))
      else $error("smi status reserved bits or read value wrong");

   AST_PP_RESET: assert property (
      @(posedge clk_in) disable iff (rst_in)
      any_aux_reset |=> st_reg.smi_status_one[SMI_PARALLEL])
      else $error("parallel bit not forced by reset");

   AST_PP_HOLD: assert property (
      @(posedge clk_in) disable iff (rst_in)
      !parallel_port_active_in [*2] |=> st_reg.smi_status_one[SMI_PARALLEL])
      else $error("parallel bit not held while inactive");

   AST_PP_TRACK: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (parallel_port_active_in && !any_aux_reset)
      |=> (st_reg.smi_status_one[SMI_PARALLEL] == $past(ack_sync)))
      else $error("parallel bit does not follow acknowledge");

   AST_WAKE_LEVEL: assert property (
      @(posedge clk_in) disable iff (rst_in)
      (s_wake_cond [*2]) |-> !wake_output_n_out [*2])
      else $error("wake output not a steady level");
endmodule : wess_top
`default_nettype wire

// *** tb/wess_pm_model.sv ***
// power-management controller model that watches the low-true wake line
// assumes the slice drives wake_output_n_in from clk_in; counts each wake episode
`timescale 1ns/1ps
`default_nettype none
module wess_pm_model (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        wake_output_n_in,
   input  wire logic [7:0]  wake_status_bus_in,
   output logic      [15:0] wake_count_out,
   output logic      [7:0]  bus_seen_out
);
   logic prev_reg;
   // one count per falling edge, so a pulsing wake line shows more episodes than expected
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prev_reg       <= 1'b1;
         wake_count_out <= 16'h0000;
         bus_seen_out   <= 8'h00;
      end else begin
         prev_reg     <= wake_output_n_in;
         bus_seen_out <= wake_status_bus_in;
         if (prev_reg && !wake_output_n_in) begin
            wake_count_out <= wake_count_out + 16'h0001;
         end
      end
   end
endmodule : wess_pm_model
`default_nettype wire

// *** tb/wess_top_tb.sv ***
// self-checking bench for the wake enable / smi status slice
// assumes the register port answers one cycle after each strobe
`timescale 1ns/1ps
`default_nettype none
module wess_top_tb;
   import wess_pkg::*;
   logic       clk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic [2:0] aux_rst = 3'h0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wr_data_in = 8'h00;
   logic       wr_en_in = 1'b0;
   logic       rd_en_in = 1'b0;
   logic [7:0] gin = 8'h00;
   logic       ack_n = 1'b1;
   logic       pp_act = 1'b0;
   logic [7:0] periph = 8'h00;
   logic [7:0] rd_data_out;
   logic       wake_output_n_out;
   logic [7:0] wake_status_bus_out;
   logic       irq_out;
   logic [15:0] wake_count;
   logic [7:0] bus_seen;
   int         n_errors = 0;
   int         comparisons = 0;
   int         cycles = 0;
   // smi status image of each enable-six source; parallel irq, mouse, keyboard and smbus set no bit
   logic [7:0] smi_map [8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h00, 8'h00, 8'h80, 8'h00};

   wess_top uut (
      .clk_in(clk_in), .rst_in(rst_in), .main_power_reset_in(aux_rst[0]),
      .soft_reset_in(aux_rst[1]), .host_bus_reset_in(aux_rst[2]),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
      .general_input_in(gin), .printer_acknowledge_n_in(ack_n), .parallel_port_active_in(pp_act),
      .parallel_port_irq_in(periph[0]), .serial_two_irq_in(periph[1]), .serial_one_irq_in(periph[2]),
      .floppy_irq_in(periph[3]), .mouse_irq_in(periph[4]), .keyboard_irq_in(periph[5]),
      .watchdog_event_in(periph[6]), .smbus_ctrl_event_in(periph[7]),
      .rd_data_out(rd_data_out), .wake_output_n_out(wake_output_n_out),
      .wake_status_bus_out(wake_status_bus_out), .irq_out(irq_out));

   wess_pm_model pm (
      .clk_in(clk_in), .rst_in(rst_in), .wake_output_n_in(wake_output_n_out),
      .wake_status_bus_in(wake_status_bus_out), .wake_count_out(wake_count), .bus_seen_out(bus_seen));

   always #5 clk_in = ~clk_in;

   // hang guard: the tests need about five hundred cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // sample just after the edge so registered outputs have settled
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : wait_cyc

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a; wr_data_in <= d; wr_en_in <= 1'b1;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask : wr_reg

   task automatic chk_rd(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a; rd_en_in <= 1'b1;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1 check(what, rd_data_out, exp);
   endtask : chk_rd

   task automatic chk_wake(input logic exp);
      check("wake_n", {7'h00, wake_output_n_out}, {7'h00, exp});
   endtask : chk_wake

   task automatic test_reset_values();
      chk_rd("en5", OFF_GPIO_WAKE_EN5, RST_EN5);
      chk_rd("en6", OFF_PERIPH_WAKE_EN6, RST_EN6);
      chk_rd("smi1", OFF_SMI_STATUS_ONE, RST_SMI_ONE);
      wait_cyc(1);
      check("rd idle", rd_data_out, 8'h00);
      chk_rd("unmapped", 8'h55, 8'h00);
      wr_reg(OFF_SMI_STATUS_ONE, 8'hFF);
      chk_rd("smi1 ro", OFF_SMI_STATUS_ONE, RST_SMI_ONE);
      chk_wake(1'b1);
      $display("test reset_values done");
   endtask : test_reset_values

   task automatic test_gpio_wake();
      wr_reg(OFF_WAKE_CTRL, 8'h01);
      for (int n = 0; n < 8; n++) begin
         wr_reg(OFF_GPIO_WAKE_EN5, 8'h00);
         gin <= 8'h01 << n;
         wait_cyc(6);
         chk_wake(1'b1);
         chk_rd("gpio sts", OFF_GPIO_WAKE_STS, 8'h01 << n);
         wr_reg(OFF_GPIO_WAKE_EN5, 8'h01 << n);
         wait_cyc(3);
         chk_wake(1'b0);
         gin <= 8'h00;
         wait_cyc(4);
         chk_wake(1'b0);
         wr_reg(OFF_GPIO_WAKE_STS, 8'h01 << n);
         wait_cyc(3);
         chk_wake(1'b1);
      end
      // global enable off must hold wake back even with an enabled latched source
      gin <= 8'h80;
      wr_reg(OFF_WAKE_CTRL, 8'h00);
      wait_cyc(6);
      chk_wake(1'b1);
      wr_reg(OFF_WAKE_CTRL, 8'h01);
      wait_cyc(3);
      chk_wake(1'b0);
      gin <= 8'h00;
      wait_cyc(4);
      wr_reg(OFF_GPIO_WAKE_STS, 8'hFF);
      wait_cyc(3);
      chk_wake(1'b1);
      check("wake episodes", wake_count[7:0], 8'h09);
      $display("test gpio_wake done");
   endtask : test_gpio_wake

   task automatic test_irq();
      wr_reg(OFF_IRQ_MASK, 8'h01);
      wait_cyc(3);
      check("irq on", {7'h00, irq_out}, 8'h01);
      wr_reg(OFF_IRQ_STATUS, 8'h07);
      wait_cyc(3);
      check("irq cleared", {7'h00, irq_out}, 8'h00);
      chk_rd("irq mask", OFF_IRQ_MASK, 8'h01);
      gin <= 8'h01;
      wait_cyc(6);
      check("irq raised", {7'h00, irq_out}, 8'h01);
      wr_reg(OFF_IRQ_MASK, 8'h00);
      wait_cyc(3);
      check("irq masked", {7'h00, irq_out}, 8'h00);
      gin <= 8'h00;
      wait_cyc(4);
      wr_reg(OFF_GPIO_WAKE_STS, 8'hFF);
      wr_reg(OFF_IRQ_STATUS, 8'h07);
      $display("test irq done");
   endtask : test_irq

   task automatic test_peripheral();
      pp_act <= 1'b1;
      ack_n  <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         wr_reg(OFF_PERIPH_WAKE_EN6, 8'h00);
         periph <= 8'h01 << k;
         wait_cyc(3);
         check("bus disabled", wake_status_bus_out, 8'h00);
         chk_rd("smi src", OFF_SMI_STATUS_ONE, 8'h02 | smi_map[k]);
         wr_reg(OFF_SMI_STATUS_ONE, 8'hFF);
         chk_rd("smi kept", OFF_SMI_STATUS_ONE, 8'h02 | smi_map[k]);
         wr_reg(OFF_PERIPH_WAKE_EN6, 8'h01 << k);
         wait_cyc(3);
         check("bus enabled", wake_status_bus_out, 8'h01 << k);
         check("bus seen", bus_seen, 8'h01 << k);
         periph <= 8'h00;
         wait_cyc(3);
         check("bus idle", wake_status_bus_out, 8'h00);
         chk_rd("smi gone", OFF_SMI_STATUS_ONE, 8'h02);
      end
      $display("test peripheral done");
   endtask : test_peripheral

   task automatic test_parallel_bit();
      pp_act <= 1'b0;
      ack_n  <= 1'b0;
      wait_cyc(5);
      chk_rd("pp idle", OFF_SMI_STATUS_ONE, 8'h02);
      pp_act <= 1'b1;
      wait_cyc(5);
      chk_rd("pp ack low", OFF_SMI_STATUS_ONE, 8'h00);
      ack_n <= 1'b1;
      wait_cyc(5);
      chk_rd("pp ack high", OFF_SMI_STATUS_ONE, 8'h02);
      $display("test parallel_bit done");
   endtask : test_parallel_bit

   task automatic test_resets();
      wr_reg(OFF_GPIO_WAKE_EN5, 8'hA5);
      wr_reg(OFF_PERIPH_WAKE_EN6, 8'h5A);
      ack_n <= 1'b0;
      for (int r = 0; r < 3; r++) begin
         wait_cyc(5);
         chk_rd("smi before", OFF_SMI_STATUS_ONE, 8'h00);
         aux_rst[r] <= 1'b1;
         wait_cyc(2);
         chk_rd("smi forced", OFF_SMI_STATUS_ONE, 8'h02);
         aux_rst[r] <= 1'b0;
      end
      chk_rd("en5 kept", OFF_GPIO_WAKE_EN5, 8'hA5);
      chk_rd("en6 kept", OFF_PERIPH_WAKE_EN6, 8'h5A);
      rst_in <= 1'b1;
      wait_cyc(2);
      rst_in <= 1'b0;
      wait_cyc(2);
      chk_rd("en5 cleared", OFF_GPIO_WAKE_EN5, RST_EN5);
      chk_rd("en6 cleared", OFF_PERIPH_WAKE_EN6, RST_EN6);
      $display("test resets done");
   endtask : test_resets

   initial begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      test_reset_values();
      test_gpio_wake();
      test_irq();
      test_peripheral();
      test_parallel_bit();
      test_resets();
      results();
   end
endmodule : wess_top_tb
`default_nettype wire
